// >>> logic/sphc_serial_ctrl.sv
// sphc_serial_ctrl: modem and flow control for a DTE serial port,
// with character transmitter and receiver
// assumes all inputs synchronous to clk; buffer levels from outside
//
// Operation
// - data-set-ready low and no override: drop frames both ways
// - override set: link counts as always connected
// - frames queued while gate closed are discarded, not held
// - data-terminal-ready high whenever data-set-ready or override
// - gate closed: data-terminal-ready and request-to-send low
// - transmit only with pending char, open gate, no clear-to-send hold
// - buffer at stop level: lower request-to-send
// - buffer down to resume level: raise request-to-send again
// - hardware flow: clear-to-send low holds off the next character; a character already sending completes
// - carrier-detect and ring-indicator are ignored
// - out of reset run at the default line rate
// - line rate configurable up to the maximum rate
// - buffer holds 4 Kbytes; levels measured against it
// - port acts as DTE: drives tx, dtr, rts; samples the rest
`timescale 1ns/1ps
module sphc_serial_ctrl
(
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // serial pins, DTE view
  output logic             txData,
  input  wire logic        rxData,
  output logic             dtrOut,
  output logic             rtsOut,
  input  wire logic        dsrIn,
  input  wire logic        ctsIn,
  input  wire logic        dcdIn,
  input  wire logic        riIn,
  // configuration
  input  wire logic        forceOn,
  input  wire logic        hwFlowEn,
  input  wire logic        divLoad,
  input  wire logic [15:0] divValue,
  input  wire logic [12:0] stopLevel,
  input  wire logic [12:0] resumeLevel,
  input  wire logic [12:0] bufLevel,
  // transmit character stream
  input  wire logic        txValid,
  input  wire logic [7:0]  txChar,
  output logic             txReady,
  // receive character stream
  output logic             rxValid,
  output logic [7:0]       rxChar,
  // status
  output logic             gateOpen,
  output logic             txBusy
);
  // ----------------------------------------------------------------
  // connection gate
  // ----------------------------------------------------------------
  logic                          gate;
  logic                          ctsHold;
  logic [15:0]                   bitDiv;
  logic                          flowOff;
  sphc_pkg::sphc_tx_state_t      txState;
  logic [15:0]                   txCnt;
  logic [3:0]                    txBit;
  logic [9:0]                    txShift;
  logic                          rxActive;
  logic [15:0]                   rxCnt;
  logic [3:0]                    rxBit;
  logic [7:0]                    rxShift;
  logic                          unusedIn;

  // gate from data-set-ready or override
  assign gate     = dsrIn | forceOn;
  assign gateOpen = gate;
  assign unusedIn = dcdIn ^ riIn;
  assign ctsHold  = hwFlowEn & ~ctsIn;

  // dtr follows gate; rts follows gate and is low while flowed off
  assign dtrOut = gate;
  assign rtsOut = gate & ~flowOff;

  // ----------------------------------------------------------------
  // line rate
  // ----------------------------------------------------------------
  function automatic logic [15:0] clampDiv(input logic [15:0] d);
    if (d < 16'(sphc_pkg::DIV_MIN))
      clampDiv = 16'(sphc_pkg::DIV_MIN);
    else
      clampDiv = d;
  endfunction

  // divisor register, default rate from reset
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      bitDiv <= 16'(sphc_pkg::DIV_DEFAULT);
    else if (divLoad)
      bitDiv <= clampDiv(divValue);
  end

  // ----------------------------------------------------------------
  // receive flow control with hysteresis
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      flowOff <= 1'b0;
    else if (bufLevel >= stopLevel)
      flowOff <= 1'b1;
    else if (bufLevel <= resumeLevel)
      flowOff <= 1'b0;
  end

  // ----------------------------------------------------------------
  // transmitter
  // ----------------------------------------------------------------
  // accept when idle and no clear-to-send hold; closed gate accepts and drops
  assign txReady = (txState == sphc_pkg::SPHC_TX_IDLE) & (~gate | ~ctsHold);
  assign txBusy  = (txState == sphc_pkg::SPHC_TX_SEND);

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      txState <= sphc_pkg::SPHC_TX_IDLE;
      txCnt   <= 16'h0000;
      txBit   <= 4'h0;
      txShift <= 10'h3FF;
      txData  <= 1'b1;
    end
    else
    begin
      case (txState)
        sphc_pkg::SPHC_TX_IDLE:
        begin
          txData <= 1'b1;
          // queued char with gate closed is dropped
          if (txValid && txReady && gate)
          begin
            txShift <= {1'b1, txChar, 1'b0};
            txState <= sphc_pkg::SPHC_TX_SEND;
            txCnt   <= 16'h0000;
            txBit   <= 4'h0;
            txData  <= 1'b0;
          end
        end
        sphc_pkg::SPHC_TX_SEND:
        begin
          if (!gate)
          begin
            txState <= sphc_pkg::SPHC_TX_IDLE;
            txData  <= 1'b1;
          end
          else if (txCnt == bitDiv - 16'h0001)
          begin
            txCnt <= 16'h0000;
            if (txBit == sphc_pkg::LAST_BIT)
            begin
              txState <= sphc_pkg::SPHC_TX_IDLE;
              txData  <= 1'b1;
            end
            else
            begin
              txBit   <= txBit + 4'h1;
              txData  <= txShift[txBit + 4'h1];
            end
          end
          else
            txCnt <= txCnt + 16'h0001;
        end
        default:
          txState <= sphc_pkg::SPHC_TX_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // receiver
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      rxActive <= 1'b0;
      rxCnt    <= 16'h0000;
      rxBit    <= 4'h0;
      rxShift  <= 8'h00;
      rxValid  <= 1'b0;
      rxChar   <= 8'h00;
    end
    else
    begin
      rxValid <= 1'b0;
      if (!rxActive)
      begin
        if (!rxData)
        begin
          rxActive <= 1'b1;
          rxCnt    <= {1'b0, bitDiv[15:1]};     // first sample mid start bit
          rxBit    <= 4'h0;
        end
      end
      else if (rxCnt == 16'h0000)
      begin
        rxCnt <= bitDiv - 16'h0001;
        rxBit <= rxBit + 4'h1;
        if (rxBit == 4'h0 && rxData)
          rxActive <= 1'b0;                     // false start
        else if (rxBit == sphc_pkg::MID_SAMPLE_BITS)
        begin
          rxActive <= 1'b0;
          // deliver only with a good stop bit and open gate
          rxValid  <= rxData & gate;
          rxChar   <= rxShift;
        end
        else if (rxBit != 4'h0)
          rxShift <= {rxData, rxShift[7:1]};
      end
      else
        rxCnt <= rxCnt - 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_gate_dtr;
    @(posedge clk) disable iff (sys_rst)
    dtrOut == (dsrIn | forceOn);
  endproperty
  a_gate_dtr: assert property (p_gate_dtr)
    else $error("dtr does not follow gate");
  property p_closed_rts;
    @(posedge clk) disable iff (sys_rst)
    !(dsrIn | forceOn) |-> !rtsOut && !dtrOut;
  endproperty
  a_closed_rts: assert property (p_closed_rts)
    else $error("control outputs on while gate closed");
  property p_stop_lvl;
    @(posedge clk) disable iff (sys_rst)
    bufLevel >= stopLevel |=> !rtsOut;
  endproperty
  a_stop_lvl: assert property (p_stop_lvl)
    else $error("rts not lowered at stop level");
  property p_resume_lvl;
    @(posedge clk) disable iff (sys_rst)
    (bufLevel <= resumeLevel && bufLevel < stopLevel && gate)
      ##1 gate |-> rtsOut;
  endproperty
  a_resume_lvl: assert property (p_resume_lvl)
    else $error("rts not raised at resume level");
  property p_no_start_closed;
    @(posedge clk) disable iff (sys_rst)
    (txState == sphc_pkg::SPHC_TX_IDLE && !gate) |=>
      txState == sphc_pkg::SPHC_TX_IDLE;
  endproperty
  a_no_start_closed: assert property (p_no_start_closed)
    else $error("transmit started with gate closed");
  property p_cts_hold;
    @(posedge clk) disable iff (sys_rst)
    (txState == sphc_pkg::SPHC_TX_IDLE && hwFlowEn && !ctsIn) |=>
      txState == sphc_pkg::SPHC_TX_IDLE;
  endproperty
  a_cts_hold: assert property (p_cts_hold)
    else $error("transmit started while flowed off");
  property p_idle_mark;
    @(posedge clk) disable iff (sys_rst)
    $past(txState == sphc_pkg::SPHC_TX_IDLE) &&
      txState == sphc_pkg::SPHC_TX_IDLE |-> txData;
  endproperty
  a_idle_mark: assert property (p_idle_mark)
    else $error("line not idle without character");
  property p_rx_drop;
    @(posedge clk) disable iff (sys_rst)
    !gate |=> !rxValid;
  endproperty
  a_rx_drop: assert property (p_rx_drop)
    else $error("character delivered with gate closed");
  property p_div_min;
    @(posedge clk) disable iff (sys_rst)
    bitDiv >= 16'(sphc_pkg::DIV_MIN);
  endproperty
  a_div_min: assert property (p_div_min)
    else $error("divisor above maximum rate");

  property p_start_bit;
    @(posedge clk) disable iff (sys_rst)
    $rose(txBusy) |-> !txData;
  endproperty
  a_start_bit: assert property (p_start_bit)
    else $error("no start bit");

  c_tx_frame: cover property (@(posedge clk) $fell(txBusy));
  c_rx_char:  cover property (@(posedge clk) rxValid);
  c_flow_off: cover property (@(posedge clk) gate && $fell(rtsOut));
  c_drop:     cover property (@(posedge clk) txValid && txReady && !gate);
endmodule

// >>> common/sphc_pkg.sv
// sphc_pkg: constants for the serial port handshake control block
// assumes a 125 MHz system clock; used by logic/sphc_serial_ctrl.sv
package sphc_pkg;
  // ----------------------------------------------------------------
  // clock and line rates
  // ----------------------------------------------------------------
  localparam int CLK_HZ           = 125000000;
  localparam int BAUD_DEFAULT     = 115200;
  localparam int BAUD_MAX         = 230000;
  localparam int DIV_DEFAULT      = CLK_HZ / BAUD_DEFAULT;
  localparam int DIV_MIN          = CLK_HZ / BAUD_MAX;
  localparam int DIV_W            = 16;
  // ----------------------------------------------------------------
  // receive buffer
  // ----------------------------------------------------------------
  localparam int BUF_BYTES        = 4096;
  localparam int LVL_W            = 13;
  localparam logic [12:0] STOP_DEFAULT   = 13'hC00;
  localparam logic [12:0] RESUME_DEFAULT = 13'h400;
  // ----------------------------------------------------------------
  // character framing: start + 8 data + stop
  // ----------------------------------------------------------------
  localparam int FRAME_BITS       = 10;
  localparam logic [3:0] LAST_BIT = 4'h9;
  localparam logic [3:0] MID_SAMPLE_BITS = 4'h9;
  typedef enum logic [1:0]
  {
    SPHC_TX_IDLE = 2'b00,
    SPHC_TX_SEND = 2'b01
  } sphc_tx_state_t;
endpackage

// >>> tb/sphc_dce_model.sv
// far-side modem model: decodes txData, sends characters on rxData
// assumes bitLen matches the divisor loaded into the design
`timescale 1ns/1ps
module sphc_dce_model
(
  input  wire logic        clk,
  input  wire logic [15:0] bitLen,
  input  wire logic        txData,
  output logic             rxData,
  output logic [7:0]       gotChar,
  output int               gotCount
);
  // --------------------------------------------------------------
  // receive side of the far party, mid-bit sampling
  // --------------------------------------------------------------
  initial
  begin
    gotCount = 0;
    gotChar = 8'h00;
    rxData = 1'b1; // mark idle between characters
    forever
    begin
      @(negedge txData);
      repeat (bitLen / 2) @(posedge clk);
      for (int i = 0; i < 8; i++)
      begin
        repeat (bitLen) @(posedge clk);
        gotChar[i] = txData; // lsb first
      end
      repeat (bitLen) @(posedge clk);
      gotCount++;
    end
  end
  // one character: start, 8 data lsb first, stop
  task automatic send_byte(input logic [7:0] c);
    logic [9:0] f;
    begin
      f = {1'b1, c, 1'b0};
      for (int i = 0; i < 10; i++)
      begin
        rxData <= f[i];
        repeat (bitLen) @(posedge clk);
      end
    end
  endtask
endmodule

// >>> tb/sphc_serial_ctrl_tb.sv
// self-checking bench for sphc_serial_ctrl
// assumes the design's 125 MHz clock and synchronous reset
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin check_count++; if ((gt) !== (ex)) begin \
  err_total++; $display("BAD %s exp %h got %h", nm, ex, gt); end end
module sphc_serial_ctrl_tb;
  logic clk, sys_rst, rxData, dsrIn, ctsIn, dcdIn, riIn, forceOn;
  logic hwFlowEn, divLoad, txValid, txData, dtrOut, rtsOut, txReady;
  logic rxValid, gateOpen, txBusy;
  logic [15:0] divValue, bitLen;
  logic [12:0] stopLevel, resumeLevel, bufLevel;
  logic [7:0]  txChar, rxChar, gotChar, rxLast;
  int err_total, check_count, gotCount, rxSeen, lo, g, r;
  sphc_serial_ctrl sphc_serial_ctrl_inst
    (.clk(clk), .sys_rst(sys_rst), .txData(txData), .rxData(rxData),
     .dtrOut(dtrOut), .rtsOut(rtsOut), .dsrIn(dsrIn), .ctsIn(ctsIn),
     .dcdIn(dcdIn), .riIn(riIn), .forceOn(forceOn), .hwFlowEn(hwFlowEn),
     .divLoad(divLoad), .divValue(divValue), .stopLevel(stopLevel),
     .resumeLevel(resumeLevel), .bufLevel(bufLevel), .txValid(txValid),
     .txChar(txChar), .txReady(txReady), .rxValid(rxValid),
     .rxChar(rxChar), .gateOpen(gateOpen), .txBusy(txBusy));
  sphc_dce_model sphc_dce_model_inst
    (.clk(clk), .bitLen(bitLen), .txData(txData), .rxData(rxData),
     .gotChar(gotChar), .gotCount(gotCount));
  // --------------------------------------------------------------
  // clock, receive catcher, watchdog
  // --------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk)
    if (rxValid === 1'b1)
    begin
      rxSeen++;
      rxLast = rxChar;
    end
  initial
  begin
    repeat (90000) @(posedge clk);
    err_total++;
    finish_test();
  end
  task automatic finish_test();
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // offer a char at an edge, hold it until taken, time the start bit
  task automatic send_tx(input logic [7:0] c, output int n);
    int k;
    begin
      k = 0;
      n = 0;
      @(posedge clk);
      txChar <= c;
      txValid <= 1'b1;
      // ready looked at mid-cycle; the take is the next rising edge
      do
      begin
        @(negedge clk);
        k++;
      end
      while (txReady !== 1'b1 && k < 20000);
      if (k >= 20000)
      begin
        err_total++;
        finish_test();
      end
      @(posedge clk);
      txValid <= 1'b0;
      #1;
      while (txData === 1'b0 && n < 5000)
      begin
        n++;
        @(posedge clk);
        #1;
      end
    end
  endtask
  task automatic idle_bits(input int b);
    repeat (b * bitLen) @(posedge clk);
    #1;
  endtask
  // --------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------
  initial
  begin
    {sys_rst, dsrIn, ctsIn, dcdIn, riIn} = 5'b10000;
    {forceOn, hwFlowEn, divLoad, txValid} = 4'h0;
    {divValue, txChar, bufLevel, rxSeen} = '0;
    {err_total, check_count} = '0;
    bitLen = 16'h043D;
    stopLevel = 13'hC00;
    resumeLevel = 13'h400;
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    #1;
    `CHK("txIdle", 1'b1, txData)
    `CHK("dtrOff", 1'b0, dtrOut)
    `CHK("rtsOff", 1'b0, rtsOut)
    `CHK("busyOff", 1'b0, txBusy)
    @(posedge clk);
    dcdIn <= 1'b1;
    riIn <= 1'b1;
    idle_bits(1);
    `CHK("gateIgn", 1'b0, gateOpen | dtrOut | rtsOut)
    @(posedge clk);
    forceOn <= 1'b1;
    @(posedge clk);
    #1;
    `CHK("forceGate", 3'h7, {gateOpen, dtrOut, rtsOut})
    @(posedge clk);
    forceOn <= 1'b0;
    dsrIn <= 1'b1;
    @(posedge clk);
    #1;
    `CHK("dsrDtr", 1'b1, dtrOut)
    g = gotCount;
    send_tx(8'hA5, lo);
    `CHK("startDef", 1085, lo)
    `CHK("busyOn", 1'b1, txBusy)
    idle_bits(10);
    `CHK("busyEnd", 1'b0, txBusy)
    `CHK("txCount", g + 1, gotCount)
    `CHK("txChar", 8'hA5, gotChar)
    sphc_dce_model_inst.send_byte(8'h69);
    idle_bits(1);
    `CHK("rxCount", 1, rxSeen)
    `CHK("rxChar", 8'h69, rxLast)
    // a divisor below the fastest rate is clamped to it
    @(posedge clk);
    divValue <= 16'h0010;
    divLoad <= 1'b1;
    @(posedge clk);
    divLoad <= 1'b0;
    bitLen = 16'h021F;
    send_tx(8'h5B, lo);
    `CHK("startMax", 543, lo)
    idle_bits(10);
    `CHK("fastChar", 8'h5B, gotChar)
    // flow control levels with hysteresis
    @(posedge clk);
    bufLevel <= 13'hC00;
    idle_bits(1);
    `CHK("rtsStop", 1'b0, rtsOut)
    @(posedge clk);
    bufLevel <= 13'h800;
    idle_bits(1);
    `CHK("rtsHold", 1'b0, rtsOut)
    @(posedge clk);
    bufLevel <= 13'h400;
    idle_bits(1);
    `CHK("rtsResume", 1'b1, rtsOut)
    // stop level at the full 4 Kbyte buffer
    @(posedge clk);
    stopLevel <= 13'h1000;
    bufLevel <= 13'h0FFF;
    idle_bits(1);
    `CHK("rtsBelowFull", 1'b1, rtsOut)
    @(posedge clk);
    bufLevel <= 13'h1000;
    idle_bits(1);
    `CHK("rtsFull", 1'b0, rtsOut)
    @(posedge clk);
    bufLevel <= 13'h0000;
    stopLevel <= 13'hC00;
    idle_bits(1);
    `CHK("rtsEmpty", 1'b1, rtsOut)
    // clear-to-send hold-off, char taken on the edge after release
    @(posedge clk);
    hwFlowEn <= 1'b1;
    txChar <= 8'h81;
    txValid <= 1'b1;
    g = gotCount;
    idle_bits(12);
    `CHK("ctsReady", 1'b0, txReady)
    `CHK("ctsHeld", g, gotCount)
    `CHK("ctsLine", 2'b10, {txData, txBusy})
    @(posedge clk);
    ctsIn <= 1'b1;
    @(posedge clk);
    txValid <= 1'b0;
    idle_bits(10);
    `CHK("ctsCount", g + 1, gotCount)
    `CHK("ctsChar", 8'h81, gotChar)
    // gate closed: both directions dropped, nothing held
    @(posedge clk);
    hwFlowEn <= 1'b0;
    dsrIn <= 1'b0;
    g = gotCount;
    r = rxSeen;
    @(posedge clk);
    #1;
    `CHK("dropCtl", 2'b00, {dtrOut, rtsOut})
    send_tx(8'hF0, lo);
    `CHK("dropStart", 0, lo)
    sphc_dce_model_inst.send_byte(8'h33);
    @(posedge clk);
    dsrIn <= 1'b1;
    idle_bits(12);
    `CHK("dropTx", g, gotCount)
    `CHK("dropRx", r, rxSeen)
    // gate falling mid-character ends it at the next edge
    send_tx(8'h01, lo);
    `CHK("abortStart", 543, lo)
    @(posedge clk);
    dsrIn <= 1'b0;
    @(posedge clk);
    #1;
    `CHK("abortTx", 2'b10, {txData, txBusy})
    finish_test();
  end
endmodule
